// [core/mlink_regs.svh]
// Constants for the supply-line command link: bus offsets, frame figures, timing.
// Included by the link top; holds definitions only.
`ifndef MLINK_REGS_SVH
`define MLINK_REGS_SVH

`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_MEMWR       8'h08
`define CTRL_DISABLE    0
`define CTRL_SPI_MODE   1
`define MEMWR_ADDR_LSB  16
`define ACCESS_ADDR     6'h3F
`define ACCESS_DATA     16'h62D2
`define CRC_SEED        3'h7
`define READ_BITS       5'h0E
`define WRITE_BITS      5'h1E
`define RD_PAYLOAD      5'h0B
`define WR_PAYLOAD      5'h1B
`define RESP_PAYLOAD    5'h16
`define RESP_HALVES     6'h36
`define MIN_BIT_CYC     8'h08
`define TX_LEAD         8'h02

`endif

// [core/mlink_pkg.sv]
// Types shared by the supply-line command link.
// Frame layouts are MSB first, in the order the bits travel on the line.
package mlink_pkg;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_MEAS  = 3'b001,
        RX_SYNC2 = 3'b010,
        RX_BITS  = 3'b011,
        RX_PROC  = 3'b100
    } rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_SEND = 2'b10
    } tx_state_t;

    typedef struct packed {
        logic       rw;
        logic [3:0] tgt;
        logic [5:0] addr;
        logic [2:0] crc;
    } rd_frame_t;

    typedef struct packed {
        logic        rw;
        logic [3:0]  tgt;
        logic [5:0]  addr;
        logic [15:0] data;
        logic [2:0]  crc;
    } wr_frame_t;

    typedef struct packed {
        logic [1:0]  sync;
        logic [1:0]  id;
        logic        bc;
        logic        ae;
        logic        ovr;
        logic        cs;
        logic [15:0] data;
        logic [2:0]  crc;
    } resp_t;

endpackage : mlink_pkg

// [core/serial_mem.sv]
// Serial register store: one word holds an even byte (high) and odd byte (low).
// Assumes one write port and one read port on the same clock.
`timescale 1ns/100ps
module serial_mem #(
    parameter int AW = 5,
    parameter int DW = 16
) (
    input  wire logic          clk,    // Core clock
    input  wire logic          arst_n, // Async reset, active low
    input  wire logic          we,     // Write strobe
    input  wire logic [1:0]    wbe,    // Byte lanes: [1] high byte, [0] low byte
    input  wire logic [AW-1:0] waddr,  // Write word address
    input  wire logic [DW-1:0] wdata,  // Write data
    input  wire logic          re,     // Read strobe
    input  wire logic [AW-1:0] raddr,  // Read word address
    output logic      [DW-1:0] rdata   // Registered read data
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (we && wbe[1]) begin
            mem[waddr][DW-1:DW/2] <= wdata[DW-1:DW/2];
        end
        if (we && wbe[0]) begin
            mem[waddr][DW/2-1:0] <= wdata[DW/2-1:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule : serial_mem

// [core/manchester_link.sv]
// Sensor side of the supply-line Manchester command link with read responses.
// Assumes supply_rx is already a clean logic level synchronous to core_clk, idle high.
// How it works
// - Valid addressed read is answered Manchester-coded on the open-drain response pin.
// - Each response carries a status field: identifier and recorded errors.
// - Response: two zero sync, 2-bit ID, four flags, 16 data, 3-bit CRC.
// - ID field is the strapped die identity, forced to 00 when broadcast.
// - Broadcast flag set for all-zero target or when SPI mode is active.
// - Abort flag set when bit edges fail after sync was detected.
// - Overrun flag set when a command completes during a response.
// - Checksum flag set when a received command had a bad CRC.
// - Error flags held until reported in a response, then cleared.
// - Access and exit codes act on every die whatever the target field.
// - Write to address all ones with access value enters serial mode.
// - Write to address all ones with any other value leaves serial mode.
// - Read command: rw one, no data, CRC; address selects returned register.
// - No read is answered before the access code is received.
// - Even address returns even/odd bytes; odd address returns odd byte only.
// - Response begins at the end of the read CRC, within a quarter bit.
// - Rising mid-bit edge is 0, falling is 1; MSB first.
// - Command: two zero sync, rw, 4-bit target, 6-bit address, data, CRC.
// - Target bit n selects die n; all-zero target selects every die.
// - CRC x^3+x+1 over bits after sync, seeded ones, MSB first.
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`include "mlink_regs.svh"
module manchester_link #(
    parameter int RATE_W = 18
) (
    input  wire logic        core_clk,        // 250 MHz core clock
    input  wire logic        arst_n,          // Async reset, active low
    input  wire logic [7:0]  avs_address,     // Avalon byte address
    input  wire logic        avs_read,        // Avalon read
    input  wire logic        avs_write,       // Avalon write
    input  wire logic [31:0] avs_writedata,   // Avalon write data
    input  wire logic [3:0]  avs_byteenable,  // Avalon byte lanes
    output logic      [31:0] avs_readdata,    // Avalon read data
    output logic             avs_waitrequest, // Avalon stall
    input  wire logic        supply_rx,       // Supply-line command level
    input  wire logic        id_strap_low,    // Die identity bit 0 strap
    input  wire logic        id_strap_high,   // Die identity bit 1 strap
    output logic             resp_pin_o,      // Response pin data, always low
    output logic             resp_pin_oe_n    // Low while pulling the pin low
);
    mlink_pkg::rx_state_t rx_state_reg;
    mlink_pkg::tx_state_t tx_state_reg;
    mlink_pkg::rd_frame_t rf;
    mlink_pkg::wr_frame_t wf;
    mlink_pkg::resp_t     resp;
    logic [RATE_W-1:0]    rx_cnt_reg, bit_t_reg, tx_cnt_reg;
    logic [RATE_W-1:0]    half_t, early_t, late_t;
    logic [`WRITE_BITS-1:0] rx_sr_reg;
    logic [4:0]           nbits_reg;
    logic [26:0]          tx_sr_reg;
    logic [5:0]           tx_half_reg;
    logic [1:0]           die_id_reg;
    logic [15:0]          mem_rdata, mem_wdata, av_data_reg;
    logic [5:0]           mem_addr, av_addr_reg;
    logic                 line_reg, rise_seen_reg, rw_reg, strap_done_reg;
    logic                 comm_mode_reg, ctrl_disable_reg, ctrl_spi_reg;
    logic                 ae_reg, ovr_reg, cs_reg, odd_reg, bc_reg, tx_first_reg;
    logic                 av_pend_reg, av_commit;
    logic                 rise, fall, proc, crc_ok, good, special, match;
    logic                 link_we, rd_go, load, ae_set, done_bit;
    logic [3:0]           tgt;
    logic [31:0]          rd_mux;

    function automatic logic [2:0] crc_of(input logic [26:0] bits, input logic [4:0] n);
        logic [2:0] c;
        c = `CRC_SEED;
        for (int i = 26; i >= 0; i--) begin
            if (i < int'(n)) begin
                c = {c[1], c[2] ^ bits[i] ^ c[0], c[2] ^ bits[i]};
            end
        end
        return c;
    endfunction : crc_of

    assign half_t  = bit_t_reg >> 1;
    assign early_t = bit_t_reg - (bit_t_reg >> 2);
    assign late_t  = bit_t_reg + (bit_t_reg >> 2);
    assign rise    = supply_rx & ~line_reg;
    assign fall    = ~supply_rx & line_reg;

    assign rf      = mlink_pkg::rd_frame_t'(rx_sr_reg[`READ_BITS-1:0]);
    assign wf      = mlink_pkg::wr_frame_t'(rx_sr_reg);
    assign tgt     = rw_reg ? rf.tgt : wf.tgt;
    assign proc    = rx_state_reg == mlink_pkg::RX_PROC;
    // CRC check over the bits after sync
    assign crc_ok  = rw_reg
        ? (crc_of(27'({rf.rw, rf.tgt, rf.addr}), `RD_PAYLOAD) == rf.crc)
        : (crc_of({wf.rw, wf.tgt, wf.addr, wf.data}, `WR_PAYLOAD) == wf.crc);
    assign good    = proc && crc_ok;
    assign special = good && !rw_reg && wf.addr == `ACCESS_ADDR;
    // target bit per die, zero selects all
    assign match   = tgt == 4'h0 || tgt[die_id_reg];
    // writes only once serial mode is entered
    assign link_we = good && !rw_reg && !special && comm_mode_reg && match;
    // read answered only in serial mode
    assign rd_go   = good && rw_reg && comm_mode_reg && match
                     && tx_state_reg == mlink_pkg::TX_IDLE;
    assign load    = tx_state_reg == mlink_pkg::TX_WAIT && tx_cnt_reg == '0;
    assign ae_set  = rx_state_reg == mlink_pkg::RX_BITS && rx_cnt_reg > late_t
                     && !((rise || fall) && rx_cnt_reg >= early_t);
    assign done_bit = (nbits_reg == `READ_BITS - 5'h01 && rw_reg)
                      || nbits_reg == `WRITE_BITS - 5'h01;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            die_id_reg     <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            die_id_reg     <= {id_strap_high, id_strap_low};
            strap_done_reg <= 1'b1;
        end
    end

    // Receiver: measures bit period on sync, then tracks mid-bit edges
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_state_reg  <= mlink_pkg::RX_IDLE;
            rx_cnt_reg    <= '0;
            bit_t_reg     <= '0;
            rx_sr_reg     <= '0;
            nbits_reg     <= 5'h00;
            line_reg      <= 1'b1;
            rise_seen_reg <= 1'b0;
            rw_reg        <= 1'b0;
        end else begin
            line_reg <= supply_rx;
            unique case (rx_state_reg)
                mlink_pkg::RX_IDLE: begin
                    rx_cnt_reg    <= '0;
                    rise_seen_reg <= 1'b0;
                    if (fall && !ctrl_disable_reg) begin
                        rx_state_reg <= mlink_pkg::RX_MEAS;
                    end
                end
                mlink_pkg::RX_MEAS: begin
                    rx_cnt_reg <= rx_cnt_reg + 1'b1;
                    if (rise) begin
                        rise_seen_reg <= 1'b1;
                    end
                    if (fall) begin
                        rx_cnt_reg <= '0;
                        if (rise_seen_reg && rx_cnt_reg >= RATE_W'(`MIN_BIT_CYC)) begin
                            bit_t_reg    <= rx_cnt_reg + 1'b1;
                            rx_state_reg <= mlink_pkg::RX_SYNC2;
                        end else begin
                            rx_state_reg <= mlink_pkg::RX_IDLE;
                        end
                    end else if (rx_cnt_reg[RATE_W-1]) begin
                        rx_state_reg <= mlink_pkg::RX_IDLE;
                    end
                end
                mlink_pkg::RX_SYNC2: begin
                    rx_cnt_reg <= rx_cnt_reg + 1'b1;
                    if (rise) begin
                        rx_cnt_reg   <= '0;
                        nbits_reg    <= 5'h00;
                        rx_state_reg <= mlink_pkg::RX_BITS;
                    end else if (fall || rx_cnt_reg > bit_t_reg) begin
                        rx_state_reg <= mlink_pkg::RX_IDLE;
                    end
                end
                mlink_pkg::RX_BITS: begin
                    rx_cnt_reg <= rx_cnt_reg + 1'b1;
                    if ((rise || fall) && rx_cnt_reg >= early_t) begin
                        rx_cnt_reg <= '0;
                        rx_sr_reg  <= {rx_sr_reg[`WRITE_BITS-2:0], fall};
                        nbits_reg  <= nbits_reg + 5'h01;
                        if (nbits_reg == 5'h00) begin
                            rw_reg <= fall;
                        end
                        if (done_bit) begin
                            rx_state_reg <= mlink_pkg::RX_PROC;
                        end
                    end else if (ae_set) begin
                        rx_state_reg <= mlink_pkg::RX_IDLE;
                    end
                end
                mlink_pkg::RX_PROC: begin
                    rx_state_reg <= mlink_pkg::RX_IDLE;
                end
                default: begin
                    rx_state_reg <= mlink_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // access value enters, any other value leaves
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            comm_mode_reg <= 1'b0;
        end else if (special) begin
            comm_mode_reg <= wf.data == `ACCESS_DATA;
        end
    end

    // set wins over the clear taken at response load
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ae_reg  <= 1'b0;
            ovr_reg <= 1'b0;
            cs_reg  <= 1'b0;
        end else begin
            ae_reg  <= (ae_reg & ~load) | ae_set;
            ovr_reg <= (ovr_reg & ~load) | (proc && tx_state_reg != mlink_pkg::TX_IDLE);
            cs_reg  <= (cs_reg & ~load) | (proc && !crc_ok);
        end
    end

    assign mem_addr  = link_we ? wf.addr : av_addr_reg;
    assign mem_wdata = link_we ? wf.data : av_data_reg;

    serial_mem #(
        .AW (5),
        .DW (16)
    ) u_mem (
        .clk    (core_clk),
        .arst_n (arst_n),
        .we     (link_we || av_pend_reg),
        .wbe    (mem_addr[0] ? 2'b01 : 2'b11),
        .waddr  (mem_addr[5:1]),
        .wdata  (mem_wdata),
        // read address selects the returned register
        .re     (rd_go),
        .raddr  (rf.addr[5:1]),
        .rdata  (mem_rdata)
    );

    always_comb begin
        resp.sync = 2'b00;
        // broadcast by zero target or SPI mode
        resp.bc   = bc_reg;
        resp.id   = bc_reg ? 2'b00 : die_id_reg;
        // recorded errors into the status field
        resp.ae   = ae_reg;
        resp.ovr  = ovr_reg;
        resp.cs   = cs_reg;
        // odd address returns the odd byte only
        resp.data = odd_reg ? {8'h00, mem_rdata[7:0]} : mem_rdata;
        resp.crc  = crc_of(27'({resp.id, resp.bc, resp.ae, resp.ovr, resp.cs, resp.data}),
                           `RESP_PAYLOAD);
    end

    // Transmitter: half-bit timer at the recovered rate
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_state_reg  <= mlink_pkg::TX_IDLE;
            tx_cnt_reg    <= '0;
            tx_sr_reg     <= '0;
            tx_half_reg   <= 6'h00;
            tx_first_reg  <= 1'b0;
            odd_reg       <= 1'b0;
            bc_reg        <= 1'b0;
            resp_pin_o    <= 1'b0;
            resp_pin_oe_n <= 1'b1;
        end else begin
            unique case (tx_state_reg)
                mlink_pkg::TX_IDLE: begin
                    resp_pin_oe_n <= 1'b1;
                    if (rd_go) begin
                        odd_reg      <= rf.addr[0];
                        bc_reg       <= rf.tgt == 4'h0 || ctrl_spi_reg;
                        // start lands on the end of the last CRC bit
                        tx_cnt_reg   <= half_t - RATE_W'(`TX_LEAD);
                        tx_state_reg <= mlink_pkg::TX_WAIT;
                    end
                end
                mlink_pkg::TX_WAIT: begin
                    tx_cnt_reg <= tx_cnt_reg - 1'b1;
                    if (load) begin
                        // frame order from the packed layout
                        tx_sr_reg     <= resp;
                        tx_half_reg   <= 6'h00;
                        tx_first_reg  <= 1'b1;
                        tx_cnt_reg    <= half_t - 1'b1;
                        resp_pin_oe_n <= resp.sync[1];
                        tx_state_reg  <= mlink_pkg::TX_SEND;
                    end
                end
                mlink_pkg::TX_SEND: begin
                    tx_cnt_reg <= tx_cnt_reg - 1'b1;
                    if (tx_cnt_reg == '0) begin
                        tx_cnt_reg  <= half_t - 1'b1;
                        tx_half_reg <= tx_half_reg + 6'h01;
                        if (tx_half_reg == `RESP_HALVES - 6'h01) begin
                            resp_pin_oe_n <= 1'b1;
                            tx_state_reg  <= mlink_pkg::TX_IDLE;
                        end else if (tx_first_reg) begin
                            // second half is the inverse level
                            resp_pin_oe_n <= ~tx_sr_reg[26];
                            tx_first_reg  <= 1'b0;
                        end else begin
                            resp_pin_oe_n <= tx_sr_reg[25];
                            tx_sr_reg     <= {tx_sr_reg[25:0], 1'b0};
                            tx_first_reg  <= 1'b1;
                        end
                    end
                end
                default: begin
                    tx_state_reg <= mlink_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // Avalon slave: waitrequest drops one cycle after a request, commit at the next edge
    assign av_commit = (avs_read || avs_write) && !avs_waitrequest;

    always_comb begin
        unique case (avs_address)
            `OFS_CTRL:   rd_mux = {30'h0, ctrl_spi_reg, ctrl_disable_reg};
            `OFS_STATUS: rd_mux = {24'h0, die_id_reg, cs_reg, ovr_reg, ae_reg,
                                   tx_state_reg != mlink_pkg::TX_IDLE,
                                   rx_state_reg != mlink_pkg::RX_IDLE, comm_mode_reg};
            default:     rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_mux : 32'h0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_disable_reg <= 1'b0;
            ctrl_spi_reg     <= 1'b0;
            av_pend_reg      <= 1'b0;
            av_addr_reg      <= 6'h00;
            av_data_reg      <= 16'h0;
        end else begin
            if (av_pend_reg && !link_we) begin
                av_pend_reg <= 1'b0;
            end
            if (av_commit && avs_write && avs_byteenable[0]) begin
                if (avs_address == `OFS_CTRL) begin
                    ctrl_disable_reg <= avs_writedata[`CTRL_DISABLE];
                    ctrl_spi_reg     <= avs_writedata[`CTRL_SPI_MODE];
                end else if (avs_address == `OFS_MEMWR) begin
                    av_pend_reg <= 1'b1;
                    av_addr_reg <= avs_writedata[`MEMWR_ADDR_LSB+5:`MEMWR_ADDR_LSB];
                    av_data_reg <= avs_writedata[15:0];
                end
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence seq_access;
        special && wf.data == `ACCESS_DATA;
    endsequence
    sequence seq_exit;
        special && wf.data != `ACCESS_DATA;
    endsequence

    chk_pin_released: assert property (
        tx_state_reg != mlink_pkg::TX_SEND |-> resp_pin_oe_n)
        else $error("response pin driven outside a response");
    chk_resp_end: assert property (
        tx_state_reg == mlink_pkg::TX_SEND && tx_cnt_reg == '0
        && tx_half_reg == `RESP_HALVES - 6'h01 |=> tx_state_reg == mlink_pkg::TX_IDLE)
        else $error("response did not end after its last half bit");
    chk_id_bcast: assert property (
        load |=> tx_sr_reg[24:23] == (bc_reg ? 2'b00 : die_id_reg))
        else $error("response ID field wrong");
    chk_access_enter: assert property (
        seq_access |=> comm_mode_reg)
        else $error("access code did not enter serial mode");
    chk_exit_leave: assert property (
        seq_exit |=> !comm_mode_reg)
        else $error("exit code did not leave serial mode");
    chk_flag_clear: assert property (
        load && !ae_set && !proc |=> !ae_reg && !ovr_reg && !cs_reg)
        else $error("error flags not cleared after report");
    chk_overrun_set: assert property (
        proc && tx_state_reg != mlink_pkg::TX_IDLE |=> ovr_reg)
        else $error("overrun not recorded");
    chk_crc_discard: assert property (
        proc && !crc_ok |=> cs_reg && tx_state_reg != mlink_pkg::TX_WAIT
        && $stable(comm_mode_reg))
        else $error("bad CRC command acted upon");
    chk_locked_read: assert property (
        !comm_mode_reg && tx_state_reg == mlink_pkg::TX_IDLE
        |=> tx_state_reg == mlink_pkg::TX_IDLE)
        else $error("read answered outside serial mode");
    chk_odd_byte: assert property (
        load && odd_reg |=> tx_sr_reg[18:11] == 8'h00)
        else $error("odd read high byte not zero");
endmodule : manchester_link

// [testbench/ctrl_model.sv]
// Controller model: drives commands on the supply line, captures responses.
// Assumes the response line reads high when released and a half bit of HALF cycles.
`timescale 1ns/100ps
module ctrl_model #(
    parameter int HALF = 8
) (
    input  wire logic core_clk,  // Core clock
    input  wire logic line,      // Response line level
    output logic      supply_rx  // Command level, idle high
);
    logic [26:0] got;
    int          n_resp = 0;
    initial supply_rx = 1'b1;
    // two zero sync bits, then MSB first, rising mid edge is 0
    task automatic send(input logic [31:0] v, input int n);
        logic b;
        @(posedge core_clk);
        for (int i = n + 1; i >= 0; i--) begin
            b = (i < n) ? v[i] : 1'b0;
            supply_rx <= b;
            repeat (HALF) @(posedge core_clk);
            supply_rx <= !b;
            repeat (HALF) @(posedge core_clk);
        end
        supply_rx <= 1'b1;
    endtask : send
    // capture starts at the response's own first edge, early or late
    initial forever begin
        @(negedge line);
        repeat (HALF / 2) @(posedge core_clk);
        for (int i = 26; i >= 0; i--) begin
            got[i] = line;
            repeat (2 * HALF) @(posedge core_clk);
        end
        n_resp++;
    end
endmodule : ctrl_model

// [testbench/manchester_supply_line_serial_link_test.sv]
// Bench for the supply-line link: bus access plus command/response frames.
// Assumes die strap 01 and a bit time of 16 core clocks.
`timescale 1ns/100ps
module manchester_supply_line_serial_link_test;
    logic        core_clk = 0, arst_n = 0, avs_read = 0, avs_write = 0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, supply_rx, resp_pin_o, resp_pin_oe_n;
    wire  logic  line = resp_pin_oe_n ? 1'b1 : resp_pin_o;
    int          num_errors = 0, n_compared = 0;
    always #2 core_clk = ~core_clk;
    manchester_link i_manchester_link (.core_clk(core_clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .supply_rx(supply_rx), .id_strap_low(1'b1),
        .id_strap_high(1'b0), .resp_pin_o(resp_pin_o), .resp_pin_oe_n(resp_pin_oe_n));
    ctrl_model i_ctrl_model (.core_clk(core_clk), .line(line), .supply_rx(supply_rx));
    task automatic finish_test();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        check(k < 50, 1);
        if (k >= 50) finish_test();
    endtask : bus
    function automatic logic [2:0] crc3(input logic [31:0] v, input int n);
        logic [2:0] c;
        logic       b;
        c = 3'h7;
        for (int i = n - 1; i >= 0; i--) begin
            b = c[2] ^ v[i];
            c = {c[1], b ^ c[0], b};
        end
        return c;
    endfunction : crc3
    function automatic logic [26:0] resp(input logic [1:0] id, input logic bc,
                                         input logic [2:0] f, input logic [15:0] d);
        logic [21:0] x;
        x = {id, bc, f, d};
        return {2'b00, x, crc3(x, 22)};
    endfunction : resp
    task automatic wr(input logic [3:0] t, input logic [5:0] a, input logic [15:0] d);
        logic [26:0] f;
        f = {1'b0, t, a, d};
        i_ctrl_model.send({f, crc3(f, 27)}, 30);
        repeat (40) @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [3:0] t, input logic [5:0] a, input logic bad,
                      input logic ans, input logic [26:0] exp);
        logic [10:0] f;
        int          n0, k;
        f = {1'b1, t, a};
        n0 = i_ctrl_model.n_resp;
        i_ctrl_model.send({f, crc3(f, 11) ^ {2'b00, bad}}, 14);
        k = 0;
        while (i_ctrl_model.n_resp == n0 && k < 1000) begin
            @(posedge core_clk);
            k++;
        end
        check(i_ctrl_model.n_resp - n0, ans);
        if (ans) check(i_ctrl_model.got, exp);
        if (ans && k >= 1000) finish_test();
    endtask : rd
    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        bus(1'b1, 8'h08, {10'h000, 6'h02, 16'hA55A});
        bus(1'b0, 8'h0C, 32'h0);
        check(q, 32'h0);
        rd(4'b0010, 6'h02, 1'b0, 1'b0, 27'h0);
        wr(4'b1000, 6'h3F, 16'h62D2);
        bus(1'b0, 8'h04, 32'h0);
        check(q[7:0], 8'h41);
        rd(4'b0010, 6'h02, 1'b0, 1'b1, resp(2'b01, 1'b0, 3'h0, 16'hA55A));
        rd(4'b0000, 6'h03, 1'b0, 1'b1, resp(2'b00, 1'b1, 3'h0, 16'h005A));
        rd(4'b0010, 6'h02, 1'b1, 1'b0, 27'h0);
        rd(4'b0010, 6'h02, 1'b0, 1'b1, resp(2'b01, 1'b0, 3'h1, 16'hA55A));
        rd(4'b0110, 6'h02, 1'b0, 1'b1, resp(2'b01, 1'b0, 3'h0, 16'hA55A));
        // Frame cut after three bits
        i_ctrl_model.send(32'h0, 3);
        repeat (40) @(posedge core_clk);
        rd(4'b0010, 6'h02, 1'b0, 1'b1, resp(2'b01, 1'b0, 3'h4, 16'hA55A));
        // Second read completes while the first is being answered
        i_ctrl_model.send({1'b1, 4'b0010, 6'h02, crc3({1'b1, 4'b0010, 6'h02}, 11)}, 14);
        rd(4'b0010, 6'h02, 1'b0, 1'b1, resp(2'b01, 1'b0, 3'h0, 16'hA55A));
        rd(4'b0010, 6'h02, 1'b0, 1'b1, resp(2'b01, 1'b0, 3'h2, 16'hA55A));
        bus(1'b1, 8'h00, 32'h1);
        rd(4'b0010, 6'h02, 1'b0, 1'b0, 27'h0);
        bus(1'b1, 8'h00, 32'h2);
        bus(1'b0, 8'h00, 32'h0);
        check(q, 32'h2);
        rd(4'b0010, 6'h02, 1'b0, 1'b1, resp(2'b00, 1'b1, 3'h0, 16'hA55A));
        bus(1'b1, 8'h00, 32'h0);
        wr(4'b0010, 6'h04, 16'h1234);
        rd(4'b0010, 6'h04, 1'b0, 1'b1, resp(2'b01, 1'b0, 3'h0, 16'h1234));
        rd(4'b0100, 6'h02, 1'b0, 1'b0, 27'h0);
        wr(4'b0100, 6'h3F, 16'h0000);
        rd(4'b0010, 6'h02, 1'b0, 1'b0, 27'h0);
        finish_test();
    end
endmodule : manchester_supply_line_serial_link_test
